// >>> link_partner.sv
// Far-end model of the serial link: makes the link clock, keeps the
// output enable from a pause request, samples words and sends input words.
// Assumes the port changes its serial output on falling clock edges.
module link_partner (
  input wire logic run, // Link clock runs while high
  input wire logic pause, // Output enable held off while high
  output logic sck, // Link clock
  input wire logic so_out, // Serial data from the port
  input wire logic so_oe, // Port drives the line
  input wire logic req, // Port has a word to send
  output logic output_shift_enable_n_n, // Output enable, active low
  output logic si, // Serial data to the port
  output logic input_shift_enable_n_n, // Input enable, active low
  output logic [15:0] cap_word, // Last received word
  output logic cap_stb // High for one link cycle per word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt; // Bits taken of current word
  logic line; // Resolved data line level
  logic en_fall; // Output enable seen at the last fall

  // Idle levels at time zero
  initial
  begin
    sck = 1'b0;
    si = 1'b0;
    input_shift_enable_n_n = 1'b1;
    cnt = 5'h00;
    cap_word = 16'h0000;
    cap_stb = 1'b0;
  end

  // Clock stands low outside frames
  always
  begin
    #3;
    sck <= run ? ~sck : 1'b0;
  end

  // Enable changes only just after rises, never near a fall
  always @(posedge sck)
    output_shift_enable_n_n <= pause;

  // Remember whether the port could shift at the last fall
  always @(negedge sck)
    en_fall <= !output_shift_enable_n_n;

  // Undriven line shows the inverse, never a stale bit
  assign line = so_oe ? so_out : ~so_out;

  // Sample one bit on each rise while a word is requested and the port could shift at the last fall
  always @(posedge sck)
  begin
    cap_stb <= 1'b0;
    if (req && en_fall)
    begin
      cap_word <= {line, cap_word[15:1]};
      cnt <= (cnt == 5'h0F) ? 5'h00 : cnt + 5'h01;
      if (cnt == 5'h0F)
        cap_stb <= 1'b1;
    end
  end

  // Send one word, first bit first, changing only on falls
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      @(negedge sck);
      input_shift_enable_n_n = 1'b0;
      si = w[i];
    end
    @(negedge sck);
    input_shift_enable_n_n = 1'b1;
    si = ~si;
  endtask
endmodule

// >>> serial_port_pkg.sv
// Shared constants for the serial shift port and its word buffer.
// Assumes one core clock domain and one link clock supplied by the far end.
// Function
// R01 - Enable low-clock: drive after next rise
// R02 - Then first bit after following fall
// R03 - Bits change on falls, sampled on rises
// R04 - Last bit and request held past rise
// R05 - Far end drops enable before next fall
// R06 - Enable during high clock: drive, data at fall
// R07 - Enable may come in request's pulse
// R08 - Continuous enable: each loaded word starts
// R09 - Enabled: request and drive at same rise
// R10 - Mid-word enable drop suspends, then resumes
// R11 - Next word follows remainder without marker
// R12 - Release while high floats output quickly
// R13 - Release while low: one more bit
// R14 - Far end keeps enable stable near falls
// R15 - Capture input bit on enabled rise
// R16 - Drive starts before any valid bit
// R17 - Input read msb-first or bit-reversed
// R18 - Output load lsb-first or msb-first
// R19 - Output floats when idle or disabled
package serial_port_pkg;
  localparam int WORD_BITS = 16; // Bits per serial word
  localparam int FIFO_DEPTH = 4; // Words buffered ahead of the shifter
  localparam int CNT_W = 5; // Width of the output bit counter
  localparam logic [4:0] BITS_FULL = 5'h10; // Counter value after a word
  localparam logic [3:0] IN_LAST = 4'hF; // Input count of final bit
  localparam logic [15:0] WORD_RST = 16'h0000; // Word value after reset
  localparam logic [1:0] SYNC_RST = 2'h0; // Synchroniser value after reset

  // Reverse the bit order of one word
  function automatic logic [15:0] reverse_word(input logic [15:0] w);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < WORD_BITS; i++)
    begin
      r[i] = w[WORD_BITS - 1 - i];
    end
    return r;
  endfunction
endpackage

// >>> serial_shift_port.sv
// Serial shift port: word load and read on the core clock, shifting on
// the link clock. Assumes the far end clocks the link and keeps the
// enables stable around the documented edges.
module serial_shift_port (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic SCK, // Link clock from far end
  output logic SO_OUT, // Serial output level
  output logic SO_OE, // Serial output drive enable
  output logic OUTPUT_WORD_REQUEST, // Word ready to shift out
  input wire logic OUTPUT_SHIFT_ENABLE_N, // Far end allows shifting
  input wire logic SI, // Serial input data
  input wire logic INPUT_SHIFT_ENABLE_N, // Qualifies input bits
  input wire logic [15:0] TX_DATA, // Word to send
  input wire logic OUTPUT_LSB_FIRST_LOAD, // Load, lsb sent first
  input wire logic OUTPUT_MSB_FIRST_LOAD, // Load, msb sent first
  output logic TX_READY, // Buffer has room
  input wire logic INPUT_MSB_FIRST_READ, // Read, first bit in msb
  input wire logic INPUT_LSB_FIRST_READ, // Read, first bit in lsb
  output logic [15:0] RX_DATA, // Word read out
  output logic RX_AVAIL // Received word waiting
);
  // Core domain state
  typedef struct packed {
    logic tx_tog; // Word handed to link side
    logic [1:0] ack_s; // Acknowledge synchroniser
    logic [15:0] tx_word; // Word held for link side
    logic [1:0] rx_s; // Receive toggle synchroniser
    logic rx_seen; // Last receive toggle taken
    logic [15:0] rx_word; // Received word
    logic rx_avail; // Received word waiting
    logic [15:0] rx_data; // Read result
  } core_state_t;

  // Link rising-edge state
  typedef struct packed {
    logic [1:0] tx_s; // Handover toggle synchroniser
    logic load_tog; // Last handover loaded
    logic [15:0] word; // Word in transmission, lsb sent first
    logic busy; // Word in transmission
    logic req; // Output request
    logic en; // Output enable seen at this rise
    logic oe_a; // Drive enable, rising half
    logic [14:0] in_sr; // Input shift register
    logic [3:0] in_cnt; // Input bits so far
    logic [15:0] rx_word; // Completed input word
    logic rx_tog; // Input word completed
  } rise_state_t;

  // Link falling-edge state
  typedef struct packed {
    logic seen; // Load toggle tracked
    logic [4:0] sent; // Bits shifted of current word
    logic en; // Output enable seen at this fall
    logic data; // Current output bit
    logic oe_b; // Drive enable, falling half
  } fall_state_t;

  core_state_t cs_reg; // Core state
  core_state_t cs_next; // Core next state
  rise_state_t rs_reg; // Rising state
  rise_state_t rs_next; // Rising next state
  fall_state_t fs_reg; // Falling state
  fall_state_t fs_next; // Falling next state
  logic [1:0] srst_reg; // Reset synchroniser on link clock
  logic link_rst_n; // Link-side reset, active low
  logic fifo_in_valid; // Load strobe
  logic [15:0] fifo_in_data; // Word in send order
  logic fifo_out_valid; // Buffered word present
  logic [15:0] fifo_out_data; // Oldest buffered word
  logic fifo_pop; // Take word toward link
  logic tx_done; // Current word fully sampled
  logic tx_avail; // New word handed over
  logic shift_now; // Bit shifted at this fall

  assign link_rst_n = srst_reg[1];
  assign SO_OUT = fs_reg.data;
  assign SO_OE = rs_reg.oe_a ^ fs_reg.oe_b;
  assign OUTPUT_WORD_REQUEST = rs_reg.req;
  assign RX_DATA = cs_reg.rx_data;
  assign RX_AVAIL = cs_reg.rx_avail;

  // Normalise load order so bit 0 is always sent first
  assign fifo_in_valid = OUTPUT_LSB_FIRST_LOAD || OUTPUT_MSB_FIRST_LOAD;
  assign fifo_in_data = OUTPUT_MSB_FIRST_LOAD ?
    serial_port_pkg::reverse_word(TX_DATA) : TX_DATA; // R18

  word_fifo #(
    .WIDTH(serial_port_pkg::WORD_BITS),
    .DEPTH(serial_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(TX_READY),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  // Core side: hand words to link side, collect received words
  always_comb
  begin
    cs_next = cs_reg;
    cs_next.ack_s = {cs_reg.ack_s[0], rs_reg.load_tog};
    cs_next.rx_s = {cs_reg.rx_s[0], rs_reg.rx_tog};
    // Only one word in flight across the crossing
    fifo_pop = fifo_out_valid && (cs_reg.tx_tog == cs_reg.ack_s[1]);
    if (fifo_pop)
    begin
      cs_next.tx_word = fifo_out_data;
      cs_next.tx_tog = ~cs_reg.tx_tog;
    end
    // Read clears the waiting flag
    if (cs_reg.rx_avail && INPUT_MSB_FIRST_READ)
    begin
      cs_next.rx_data = cs_reg.rx_word; // R17
      cs_next.rx_avail = 1'b0;
    end
    else if (cs_reg.rx_avail && INPUT_LSB_FIRST_READ)
    begin
      cs_next.rx_data = serial_port_pkg::reverse_word(cs_reg.rx_word); // R17
      cs_next.rx_avail = 1'b0;
    end
    // New word wins over a read in the same cycle
    if (cs_reg.rx_s[1] != cs_reg.rx_seen)
    begin
      cs_next.rx_seen = cs_reg.rx_s[1];
      cs_next.rx_word = rs_reg.rx_word;
      cs_next.rx_avail = 1'b1;
    end
  end

  // Core state register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      cs_reg <= '0;
    end
    else
    begin
      cs_reg <= cs_next;
    end
  end

  // Reset brought onto the link clock
  always_ff @(posedge SCK)
  begin
    srst_reg <= {srst_reg[0], RST_N};
  end

  // Rising edge: load words, request, drive start, input capture
  always_comb
  begin
    rs_next = rs_reg;
    rs_next.tx_s = {rs_reg.tx_s[0], cs_reg.tx_tog};
    rs_next.en = ~OUTPUT_SHIFT_ENABLE_N;
    tx_avail = (rs_reg.tx_s[1] != rs_reg.load_tog);
    // Final bit was shifted at the last fall and is sampled now
    tx_done = rs_reg.busy && (fs_reg.seen == rs_reg.load_tog)
      && (fs_reg.sent == serial_port_pkg::BITS_FULL);
    if (!rs_reg.busy || tx_done)
    begin
      if (tx_avail)
      begin
        // Next word starts at once, request stays high
        rs_next.word = cs_reg.tx_word; // R08 R11
        rs_next.load_tog = rs_reg.tx_s[1];
        rs_next.busy = 1'b1;
        rs_next.req = 1'b1; // R09
      end
      else if (tx_done)
      begin
        // Request dropped only after the last sampling rise
        rs_next.busy = 1'b0; // R04
        rs_next.req = 1'b0; // R04
      end
    end
    // Drive from this rise if enabled, or for a pending last bit
    rs_next.oe_a = (rs_next.busy && (~OUTPUT_SHIFT_ENABLE_N || fs_reg.en))
      ^ fs_reg.oe_b; // R01 R09 R13 R16 R19
    // Input capture on enabled rises
    if (!INPUT_SHIFT_ENABLE_N)
    begin
      rs_next.in_sr = {rs_reg.in_sr[13:0], SI}; // R15
      rs_next.in_cnt = rs_reg.in_cnt + 4'h1; // R15
      if (rs_reg.in_cnt == serial_port_pkg::IN_LAST)
      begin
        rs_next.rx_word = {rs_reg.in_sr, SI}; // R17
        rs_next.rx_tog = ~rs_reg.rx_tog;
      end
    end
  end

  // Rising state register
  always_ff @(posedge SCK)
  begin
    if (!link_rst_n)
    begin
      rs_reg <= '0;
    end
    else
    begin
      rs_reg <= rs_next;
    end
  end

  // Falling edge: bit changes, suspend and resume, float on release
  always_comb
  begin
    logic [4:0] base;
    logic en_f;
    base = (fs_reg.seen != rs_reg.load_tog) ? 5'h00 : fs_reg.sent;
    en_f = ~OUTPUT_SHIFT_ENABLE_N;
    fs_next = fs_reg;
    fs_next.seen = rs_reg.load_tog;
    fs_next.sent = base;
    fs_next.en = en_f;
    // Enabled now, or released while low after an enabled fall
    shift_now = rs_reg.busy && (base < serial_port_pkg::BITS_FULL)
      && (en_f || (fs_reg.en && !rs_reg.en)); // R02 R06 R10 R13
    if (shift_now)
    begin
      fs_next.data = rs_reg.word[base[3:0]]; // R03
      fs_next.sent = base + 5'h01; // R03 R10
    end
    // Release while high floats at this fall
    fs_next.oe_b = (rs_reg.busy && (en_f || shift_now))
      ^ rs_reg.oe_a; // R06 R12 R19
  end

  // Falling state register
  always_ff @(negedge SCK)
  begin
    if (!link_rst_n)
    begin
      fs_reg <= '0;
    end
    else
    begin
      fs_reg <= fs_next;
    end
  end

  a_idle_float: assert property (@(posedge SCK) disable iff (!link_rst_n)
    !rs_reg.busy |-> !SO_OE) // R19
    else $error("output driven while idle");
  a_bit_driven: assert property (@(posedge SCK) disable iff (!link_rst_n)
    (fs_reg.sent != $past(fs_reg.sent) && fs_reg.seen == $past(fs_reg.seen))
    |-> SO_OE) // R03
    else $error("shifted bit not driven");
  a_req_release: assert property (@(posedge SCK) disable iff (!link_rst_n)
    $fell(OUTPUT_WORD_REQUEST) |-> fs_reg.sent == 5'h10) // R04
    else $error("request dropped before last bit");
  a_back_to_back: assert property (@(posedge SCK) disable iff (!link_rst_n)
    (tx_done && tx_avail) |=> OUTPUT_WORD_REQUEST) // R11
    else $error("gap between words");
  a_in_count: assert property (@(posedge SCK) disable iff (!link_rst_n)
    (!INPUT_SHIFT_ENABLE_N && rs_reg.in_cnt != 4'hF)
    |=> rs_reg.in_cnt == $past(rs_reg.in_cnt) + 4'h1) // R15
    else $error("input bit not counted");
  a_in_hold: assert property (@(posedge SCK) disable iff (!link_rst_n)
    INPUT_SHIFT_ENABLE_N |=> $stable(rs_reg.in_cnt)) // R15
    else $error("input shifted while disabled");
  a_start_req: assert property (@(posedge SCK) disable iff (!link_rst_n)
    (!rs_reg.busy && tx_avail) |=> OUTPUT_WORD_REQUEST ##0 rs_reg.busy) // R09
    else $error("request not raised on load");
  a_reversed_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (cs_reg.rx_avail && !INPUT_MSB_FIRST_READ && INPUT_LSB_FIRST_READ)
    |=> RX_DATA == serial_port_pkg::reverse_word($past(cs_reg.rx_word)))
    // R17
    else $error("reversed read wrong");
  a_rx_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (cs_reg.rx_s[1] != cs_reg.rx_seen) |=> RX_AVAIL) // R15
    else $error("received word not flagged");

  c_word_out: cover property (@(posedge SCK) disable iff (!link_rst_n)
    $fell(OUTPUT_WORD_REQUEST));
  c_chained: cover property (@(posedge SCK) disable iff (!link_rst_n)
    tx_done && tx_avail);
  c_word_in: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(RX_AVAIL));
  c_suspend: cover property (@(posedge SCK) disable iff (!link_rst_n)
    rs_reg.busy && !rs_reg.en && fs_reg.sent == 5'h08);
endmodule

// >>> test_serial_shift_port.sv
// Self-checking bench for the serial shift port with its link partner.
// Assumes the package constants and the port's hand-over timing.
module test_serial_shift_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, run, sck, so_out, so_oe, req, output_shift_enable_n_n, si, input_shift_enable_n_n;
  logic ld_lsb, ld_msb, tx_ready, rd_msb, rd_lsb, rx_avail, cap_stb;
  logic rd_done;
  logic pause; // Far end holds output enable off
  logic [15:0] tx_data, rx_data, cap_word;
  logic [15:0] txq[$]; // Expected words on the link
  logic [15:0] rxq[$]; // Expected read results
  logic [31:0] seed = 32'h0000001B; // Random state
  int n_mismatch = 0;
  int checked = 0;

  serial_shift_port DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .SCK(sck),
    .SO_OUT(so_out), .SO_OE(so_oe), .OUTPUT_WORD_REQUEST(req),
    .OUTPUT_SHIFT_ENABLE_N(output_shift_enable_n_n), .SI(si), .INPUT_SHIFT_ENABLE_N(input_shift_enable_n_n),
    .TX_DATA(tx_data), .OUTPUT_LSB_FIRST_LOAD(ld_lsb),
    .OUTPUT_MSB_FIRST_LOAD(ld_msb), .TX_READY(tx_ready),
    .INPUT_MSB_FIRST_READ(rd_msb), .INPUT_LSB_FIRST_READ(rd_lsb),
    .RX_DATA(rx_data), .RX_AVAIL(rx_avail));

  link_partner P (.run(run), .pause(pause), .sck(sck), .so_out(so_out),
    .so_oe(so_oe),
    .req(req), .output_shift_enable_n_n(output_shift_enable_n_n), .si(si), .input_shift_enable_n_n(input_shift_enable_n_n),
    .cap_word(cap_word), .cap_stb(cap_stb));

  // Core clock, 100 ns period
  always #50 core_clk = ~core_clk;

  // Xorshift random source
  function automatic logic [15:0] rnd16();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // Bit reversal of one word
  function automatic logic [15:0] rev16(input logic [15:0] w);
    logic [15:0] r;
    for (int i = 0; i < 16; i++)
      r[i] = w[15 - i];
    return r;
  endfunction

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Offer one word; strobes stay up between back-to-back loads
  task automatic load(input logic [15:0] w, input logic msb);
    if (!tx_ready)
    begin
      ld_lsb = 1'b0;
      ld_msb = 1'b0;
      for (int k = 0; k < 300 && !tx_ready; k++)
        @(negedge core_clk);
      // A buffer that never frees is a failure
      if (!tx_ready)
      begin
        n_mismatch++;
        $display("ERROR %0t: buffer stayed full", $time);
      end
    end
    tx_data = w;
    ld_msb = msb;
    ld_lsb = !msb;
    txq.push_back(msb ? rev16(w) : w);
    @(negedge core_clk);
  endtask

  // Read one received word in the chosen order
  task automatic read_word(input logic msb);
    rd_done = 1'b0;
    for (int k = 0; k < 300 && !rx_avail; k++)
      @(negedge core_clk);
    // A word that never arrives is a failure
    if (!rx_avail)
    begin
      n_mismatch++;
      $display("ERROR %0t: no received word", $time);
    end
    rd_msb = msb;
    rd_lsb = !msb;
    @(negedge core_clk);
    rd_msb = 1'b0;
    rd_lsb = 1'b0;
    rd_done = 1'b1;
  endtask

  // Wait until every expected link word has arrived
  task automatic drain();
    for (int k = 0; k < 5000 && txq.size() != 0; k++)
      @(negedge core_clk);
    check({15'h0000, txq.size() == 0}, 16'h0001);
  endtask

  // Link words against the oldest note
  always
  begin
    @(posedge cap_stb);
    #1;
    if (txq.size() == 0)
    begin
      n_mismatch++;
      $display("ERROR %0t: unexpected word %h", $time, cap_word);
    end
    else
      check(cap_word, txq.pop_front());
  end

  // Read results against the oldest note
  always
  begin
    @(posedge rd_done);
    check(rx_data, rxq.pop_front());
    check({15'h0000, rx_avail}, 16'h0000);
  end

  // Verdict and end of run
  task automatic summarize();
    $display("Counts: %0d checked, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #3000000;
    n_mismatch++;
    $display("ERROR %0t: timeout", $time);
    summarize();
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    run = 1'b1;
    tx_data = 16'h0000;
    {ld_lsb, ld_msb, rd_msb, rd_lsb, rd_done} = 5'h00;
    pause = 1'b0;
    repeat (5) @(negedge core_clk);
    check({so_oe, req, tx_ready, rx_avail}, 16'h0002);
    check(rx_data, 16'h0000);
    rst_n = 1'b1;
    $display("Reset test done");
    // Back-to-back words in both load orders
    for (int i = 0; i < 6; i++)
      load(rnd16(), i[0]);
    ld_lsb = 1'b0;
    ld_msb = 1'b0;
    drain();
    $display("Output order test done");
    // Stall the link, fill the buffer until it refuses
    run = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int n = 0; n < 8 && tx_ready; n++)
      load(rnd16(), n[1]);
    ld_msb = 1'b0;
    ld_lsb = 1'b1;
    tx_data = 16'hDEAD;
    @(negedge core_clk);
    ld_lsb = 1'b0;
    check({15'h0000, tx_ready}, 16'h0000);
    check({12'h000, txq.size() >= 4}, 16'h0001);
    run = 1'b1;
    drain();
    $display("Buffer test done");
    // Enable dropped and restored while words are in flight
    for (int i = 0; i < 4; i++)
    begin
      pause = ^rnd16();
      load(rnd16(), i[1]);
    end
    ld_lsb = 1'b0;
    ld_msb = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      pause = k[0];
      @(negedge core_clk);
    end
    pause = 1'b0;
    drain();
    $display("Enable suspend test done");
    // Input words in both read orders
    for (int m = 0; m < 2; m++)
    begin
      tx_data = rnd16();
      rxq.push_back(m[0] ? tx_data : rev16(tx_data));
      P.send_word(tx_data);
      read_word(m[0]);
      repeat (10) @(negedge core_clk);
    end
    $display("Input test done");
    summarize();
  end
endmodule

// >>> word_fifo.sv
// Small word buffer between the load strobes and the shift handshake.
// Assumes both sides run on the core clock.
module word_fifo #(
  parameter int WIDTH = 16, // Word width
  parameter int DEPTH = 4 // Number of words
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic in_valid, // Word offered
  input wire logic [WIDTH-1:0] in_data, // Offered word
  output logic in_ready, // Room for a word, registered
  output logic out_valid, // Word available
  output logic [WIDTH-1:0] out_data, // Oldest word
  input wire logic out_ready // Drain side takes the word
);
  localparam int AW = $clog2(DEPTH); // Pointer width
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
    logic [AW-1:0] wp; // Write pointer
    logic [AW-1:0] rp; // Read pointer
    logic [AW:0] cnt; // Words held
    logic not_full; // Registered ready
  } fifo_state_t;
  fifo_state_t st_reg; // Current state
  fifo_state_t st_next; // Next state
  logic push; // Accepted write
  logic pop; // Accepted read

  assign in_ready = st_reg.not_full;
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];

  // Pointer and count update
  always_comb
  begin
    st_next = st_reg;
    push = in_valid && st_reg.not_full;
    pop = out_ready && (st_reg.cnt != '0);
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = AW'(st_reg.wp + 1'b1);
    end
    if (pop)
    begin
      st_next.rp = AW'(st_reg.rp + 1'b1);
    end
    st_next.cnt = (AW + 1)'(st_reg.cnt + push - pop);
    st_next.not_full = (st_next.cnt != (AW + 1)'(DEPTH));
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.not_full <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  a_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cnt == (AW + 1)'(DEPTH) && !out_ready)
    |=> (st_reg.cnt == (AW + 1)'(DEPTH)) && !in_ready)
    else $error("full buffer took a word");
endmodule
